// ---- core/tpra_pkg.sv ----
// Constants and carrier types for the transmit port rate arbiter.
// Notes on behaviour
// - In four-port mode, grant at most one contending port per cell slot.
// - Each slot: rate eligibility first, then priority choice among eligible ports.
// - Each port holds an 8-bit rate limit, a share of a 256-slot cycle.
// - Rate zero is never eligible; rate 255 is eligible in every slot.
// - Port eligible only when its rate is at least the slot's threshold.
// - Thresholds differ per port; rate 127 gives bursts of eight, four or two, or alternation, on ports 0 to 3 in turn.
// - Rate is only an upper bound, never a guaranteed throughput.
// - Two-bit priority from config bits 3 to 2; zero is most urgent.
// - A more urgent ready eligible port always beats a less urgent one.
// - Ports sharing the most urgent level in use take turns round-robin.
// - A preempting priority-zero port keeps every slot in which it is rate eligible until its data runs out; here the hold ends at a rate-ineligible slot.
// - A loser is judged afresh next slot, rate eligibility included.
// - Arbitration applies only in four-port FIFO mode, not single-port mode.
package tpra_pkg;
  localparam int TPRA_PORTS = 4;
  localparam int TPRA_RATE_W = 8;
  localparam int TPRA_SLOTS = 256;
  localparam int TPRA_PRIO_LSB = 2;
  localparam int TPRA_PRIO_MSB = 3;
  localparam logic [1:0] TPRA_PRIO_URGENT = 2'h0;
  localparam logic [7:0] TPRA_RATE_OFF = 8'h00;
  localparam logic [7:0] TPRA_RATE_FULL = 8'hff;
  localparam logic [7:0] TPRA_SLOT_RESET = 8'h00;
  localparam logic [1:0] TPRA_PORT_RESET = 2'h3;

  // Each threshold is the slot index with its bits scattered; entry [p][b] gives the
  // threshold bit that slot bit b lands on for port p.
  localparam logic [3:0][7:0][2:0] TPRA_THR_MAP = {
    {3'h2, 3'h1, 3'h0, 3'h5, 3'h4, 3'h6, 3'h3, 3'h7},
    {3'h1, 3'h0, 3'h5, 3'h4, 3'h6, 3'h3, 3'h7, 3'h2},
    {3'h0, 3'h5, 3'h4, 3'h6, 3'h3, 3'h7, 3'h2, 3'h1},
    {3'h5, 3'h4, 3'h6, 3'h3, 3'h7, 3'h2, 3'h1, 3'h0}
  };

  typedef struct packed {
    logic [7:0] rate_limit;
    logic [7:0] cell_config;
  } tpra_port_cfg_t;

  typedef struct packed {
    logic valid;
    logic [1:0] port;
  } tpra_grant_t;
endpackage

// ---- core/tpra_rate_gate.sv ----
// Per-port threshold table and rate eligibility compare.
`timescale 1ns/100ps
module tpra_rate_gate
  import tpra_pkg::*;
#(
  parameter int PORT = 0
) (
  input wire logic [7:0] slot,
  input wire logic [7:0] rate_limit,
  output logic [7:0] threshold,
  output logic eligible
);
  logic [7:0] thr_table [TPRA_SLOTS];

  // The table folds to constants in synthesis; slot zero always maps to threshold zero.
  always_comb begin
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < TPRA_SLOTS; i++) begin
      s = i[7:0];
      thr_table[i] = 8'h00;
      for (int b = 0; b < 8; b++) begin
        thr_table[i][TPRA_THR_MAP[PORT][b]] = s[b];
      end
    end
  end

  always_comb begin
    threshold = thr_table[slot];
    // Rate zero would pass the slot-zero compare, so it is blocked outright.
    // Eligibility only caps a port; whether it wins is left to the priority stage.
    eligible = (rate_limit != TPRA_RATE_OFF) && (rate_limit >= threshold);
  end
endmodule // tpra_rate_gate

// ---- core/tpra_arbiter.sv ----
// Transmit port rate arbiter: per-slot rate gating and priority grant.
`timescale 1ns/100ps
module tpra_arbiter
  import tpra_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic slot_tick,
  input wire logic fifo_mode,
  input wire logic [TPRA_PORTS-1:0] port_empty,
  input wire tpra_port_cfg_t [TPRA_PORTS-1:0] port_cfg,
  output tpra_grant_t grant,
  output logic [7:0] slot_index
);
  logic rst_meta_ff;
  logic rst_sync_n;
  logic [7:0] slot_ff;
  logic [7:0] nxt_slot;
  tpra_grant_t grant_ff;
  tpra_grant_t nxt_grant;
  logic [1:0] rr_ff;
  logic [1:0] nxt_rr;
  logic hold_ff;
  logic nxt_hold;
  logic [1:0] last_prio_ff;
  logic [1:0] nxt_last_prio;
  logic [TPRA_PORTS-1:0] eligible;
  logic [TPRA_PORTS-1:0] cand;
  logic [1:0] prio [TPRA_PORTS];
  logic [TPRA_PORTS-1:0] cand_snap_ff;
  logic [7:0] rate_snap_ff [TPRA_PORTS];
  logic [7:0] thr_snap_ff [TPRA_PORTS];
  logic [7:0] thr [TPRA_PORTS];
  logic rst_sync_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_sync_n = rst_sync_ff;

  for (genvar p = 0; p < TPRA_PORTS; p++) begin : g_port
    tpra_rate_gate #(.PORT(p)) u_gate (
      .slot(slot_ff),
      .rate_limit(port_cfg[p].rate_limit),
      .threshold(thr[p]),
      .eligible(eligible[p])
    );
    assign prio[p] = port_cfg[p].cell_config[TPRA_PRIO_MSB:TPRA_PRIO_LSB];
    // Judged afresh each slot, so a loser may drop out on rate next slot.
    assign cand[p] = eligible[p] && !port_empty[p];
  end

  always_comb begin
    logic [1:0] best;
    logic found;
    logic [1:0] idx;
    best = 2'h3;
    found = 1'b0;
    idx = 2'h0;
    nxt_slot = slot_ff;
    nxt_grant = '{valid: 1'b0, port: grant_ff.port};
    nxt_rr = rr_ff;
    nxt_hold = hold_ff;
    nxt_last_prio = last_prio_ff;
    if (slot_tick) begin
      nxt_slot = slot_ff + 8'h01;
      if (fifo_mode) begin
        for (int p = 0; p < TPRA_PORTS; p++) begin
          if (cand[p] && prio[p] < best) begin
            best = prio[p];
          end
        end
        if (hold_ff && cand[rr_ff] && prio[rr_ff] == TPRA_PRIO_URGENT) begin
          // The preempting urgent port keeps every slot until its FIFO drains or it misses a slot on rate.
          nxt_grant = '{valid: 1'b1, port: rr_ff};
        end else begin
          for (int k = 1; k <= TPRA_PORTS; k++) begin
            idx = 2'(rr_ff + k[1:0]);
            if (!found && cand[idx] && prio[idx] == best) begin
              found = 1'b1;
              nxt_grant = '{valid: 1'b1, port: idx};
            end
          end
        end
        if (nxt_grant.valid) begin
          nxt_rr = nxt_grant.port;
          // The level of the previous slot's winner, urgent when that slot had no grant,
          // so the preemption test does not depend on how far apart the ticks are.
          nxt_hold = (prio[nxt_grant.port] == TPRA_PRIO_URGENT) &&
                     (hold_ff || (last_prio_ff != TPRA_PRIO_URGENT));
          nxt_last_prio = prio[nxt_grant.port];
        end else begin
          nxt_hold = 1'b0;
          nxt_last_prio = TPRA_PRIO_URGENT;
        end
      end else begin
        nxt_hold = 1'b0;
        nxt_last_prio = TPRA_PRIO_URGENT;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      slot_ff <= TPRA_SLOT_RESET;
      grant_ff <= '{valid: 1'b0, port: TPRA_PORT_RESET};
      rr_ff <= TPRA_PORT_RESET;
      hold_ff <= 1'b0;
      last_prio_ff <= TPRA_PRIO_URGENT;
    end else begin
      slot_ff <= nxt_slot;
      grant_ff <= nxt_grant;
      rr_ff <= nxt_rr;
      hold_ff <= nxt_hold;
      last_prio_ff <= nxt_last_prio;
    end
  end

  // Snapshot of the decision inputs, read only by the checks below.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cand_snap_ff <= '0;
      for (int p = 0; p < TPRA_PORTS; p++) begin
        rate_snap_ff[p] <= TPRA_RATE_OFF;
        thr_snap_ff[p] <= TPRA_SLOT_RESET;
      end
    end else begin
      cand_snap_ff <= cand;
      for (int p = 0; p < TPRA_PORTS; p++) begin
        rate_snap_ff[p] <= port_cfg[p].rate_limit;
        thr_snap_ff[p] <= thr[p];
      end
    end
  end

  assign grant = grant_ff;
  assign slot_index = slot_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  sequence tick_in_mode_s;
    slot_tick && fifo_mode && (cand != '0);
  endsequence

  sequence grant_pulse_s;
    grant.valid ##1 !grant.valid || grant.valid;
  endsequence

  grant_on_contend_a: assert property (tick_in_mode_s |=> grant.valid)
    else $error("No grant after a slot with a ready eligible port.");
  grant_needs_tick_a: assert property (grant.valid |-> $past(slot_tick) && $past(fifo_mode))
    else $error("Grant issued without a slot tick in four-port mode.");
  grant_cand_only_a: assert property (grant.valid |-> cand_snap_ff[grant.port])
    else $error("Granted port was empty or not rate eligible.");
  rate_zero_never_a: assert property (grant.valid |-> rate_snap_ff[grant.port] != 8'h00)
    else $error("Port with rate zero was granted.");
  rate_threshold_a: assert property (grant.valid |->
      rate_snap_ff[grant.port] >= thr_snap_ff[grant.port])
    else $error("Granted port rate below its slot threshold.");
  full_rate_elig_a: assert property (port_cfg[0].rate_limit == 8'hff |-> eligible[0])
    else $error("Rate 255 port not eligible.");
  burst_of_eight_a: assert property (port_cfg[0].rate_limit == 8'h7f |->
      eligible[0] == !slot_ff[3])
    else $error("Port zero burst pattern wrong at rate 127.");
  alternate_port3_a: assert property (port_cfg[3].rate_limit == 8'h7f |->
      eligible[3] == !slot_ff[0])
    else $error("Port three alternation wrong at rate 127.");
  urgent_first_a: assert property (grant.valid && cand_snap_ff[0] && cand_snap_ff[1] &&
      $past(prio[0]) < $past(prio[1]) |-> grant.port != 2'h1)
    else $error("Less urgent port beat a more urgent one.");
  slot_wrap_a: assert property (slot_tick && slot_ff == 8'hff |=> slot_ff == 8'h00)
    else $error("Slot counter did not wrap to zero.");
  hold_keeps_a: assert property (hold_ff && slot_tick && fifo_mode && cand[rr_ff] &&
      prio[rr_ff] == 2'h0 |=> grant.valid && grant.port == $past(rr_ff))
    else $error("Preempting urgent port lost its slot while it had data.");
  rr_turns_a: assert property (slot_tick && fifo_mode && !hold_ff && cand == 4'h6 &&
      prio[1] == prio[2] && cand[rr_ff] |=> grant.valid && grant.port != $past(rr_ff))
    else $error("Round-robin repeated a port while another shared the level.");
  grant_pulse_a: assert property (grant.valid && !$past(slot_tick, 1) |-> 1'b0)
    else $error("Grant pulse not tied to a slot decision.");
endmodule // tpra_arbiter

// ---- bench/tpra_fifo_model.sv ----
// Behavioural model of the four external transmit FIFOs that feed the arbiter.
`timescale 1ns/100ps
module tpra_fifo_model
  import tpra_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic load,
  input wire logic flush,
  input wire logic [3:0][7:0] fill,
  input wire tpra_grant_t grant,
  output logic [TPRA_PORTS-1:0] port_empty
);
  logic [3:0][7:0] count_ff;

  // Each grant takes one cell from the granted port; flush empties every port at once.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else begin
      for (int p = 0; p < TPRA_PORTS; p++) begin
        if (flush) count_ff[p] <= 8'h00;
        else count_ff[p] <= count_ff[p] + (load ? fill[p] : 8'h00)
                            - ((grant.valid && grant.port == p) ? 8'h01 : 8'h00);
      end
    end
  end

  always_comb begin
    for (int p = 0; p < TPRA_PORTS; p++) port_empty[p] = (count_ff[p] == 8'h00);
  end
endmodule // tpra_fifo_model

// ---- bench/tpra_arbiter_bench.sv ----
// Self-checking bench for the transmit port rate arbiter.
`timescale 1ns/100ps
module tpra_arbiter_bench import tpra_pkg::*;;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic slot_tick = 1'b0;
  logic fifo_mode = 1'b1;
  logic load = 1'b0;
  logic flush = 1'b0;
  logic [3:0][7:0] fill = '0;
  tpra_port_cfg_t [TPRA_PORTS-1:0] port_cfg = '0;
  logic [TPRA_PORTS-1:0] port_empty;
  tpra_grant_t grant;
  logic [7:0] slot_index;
  logic [7:0] slot = 8'h00;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #2 clock = ~clock;

  tpra_arbiter u_tpra_arbiter (.clock(clock), .rst_n(rst_n), .slot_tick(slot_tick),
    .fifo_mode(fifo_mode), .port_empty(port_empty), .port_cfg(port_cfg), .grant(grant),
    .slot_index(slot_index));
  tpra_fifo_model u_tpra_fifo_model (.clock(clock), .rst_n(rst_n), .load(load),
    .flush(flush), .fill(fill), .grant(grant), .port_empty(port_empty));

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // The whole run needs about 900 cycles; this ceiling leaves ample slack.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Unused configuration bits are set on purpose so that only bits 3 to 2 may count.
  function automatic tpra_port_cfg_t cfg(input logic [7:0] rate, input logic [1:0] prio);
    return {rate, 4'ha, prio, 2'h1};
  endfunction

  // One cell slot: tick, then judge the grant in the one cycle that it stands.
  task automatic tick(input logic v, input logic [1:0] p);
    @(posedge clock) #1 slot_tick = 1'b1;
    @(posedge clock) #1 slot_tick = 1'b0;
    slot = slot + 8'h01;
    chk("grant_valid", {7'h0, v}, {7'h0, grant.valid});
    if (v) chk("grant_port", {6'h0, p}, {6'h0, grant.port});
    chk("slot_index", slot, slot_index);
    @(posedge clock) #1;
  endtask

  // Flush or top up the FIFOs; configuration only changes right after a flush.
  task automatic fifo(input logic [3:0][7:0] f, input logic fl);
    @(posedge clock) #1 fill = f;
    load = !fl;
    flush = fl;
    @(posedge clock) #1 load = 1'b0;
    flush = 1'b0;
  endtask

  task automatic setup(input tpra_port_cfg_t c3, c2, c1, c0, input logic [31:0] f);
    fifo('0, 1'b1);
    port_cfg = {c3, c2, c1, c0};
    fifo(f, 1'b0);
  endtask

  task automatic t_rate_ends();
    setup(cfg(8'h00, 2'h3), cfg(8'h00, 2'h3), cfg(8'h00, 2'h0), cfg(8'hff, 2'h0), 32'h0404);
    repeat (4) tick(1'b1, 2'h0);
    repeat (4) tick(1'b0, 2'h0);
    $display("Test rate_ends done");
  endtask

  task automatic t_burst();
    setup(cfg(8'h00, 2'h3), cfg(8'h00, 2'h3), cfg(8'h00, 2'h3), cfg(8'h7f, 2'h0), 32'h10);
    repeat (32) tick(!slot[3], 2'h0);
    setup(cfg(8'h7f, 2'h0), cfg(8'h00, 2'h3), cfg(8'h00, 2'h3), cfg(8'h00, 2'h3), 32'h10 << 24);
    repeat (32) tick(!slot[0], 2'h3);
    $display("Test burst done");
  endtask

  task automatic t_prio_rr();
    setup(cfg(8'h00, 2'h1), cfg(8'hff, 2'h1), cfg(8'hff, 2'h1), cfg(8'hff, 2'h0), 32'h40403);
    repeat (3) tick(1'b1, 2'h0);
    for (int i = 0; i < 8; i++) tick(1'b1, i[0] ? 2'h2 : 2'h1);
    tick(1'b0, 2'h0);
    $display("Test prio_rr done");
  endtask

  task automatic t_hold();
    setup(cfg(8'hff, 2'h0), cfg(8'h00, 2'h1), cfg(8'hff, 2'h1), cfg(8'hff, 2'h0), 32'h800);
    repeat (2) tick(1'b1, 2'h1);
    fifo(32'h02000002, 1'b0);
    repeat (2) tick(1'b1, 2'h3);
    repeat (2) tick(1'b1, 2'h0);
    repeat (2) tick(1'b1, 2'h1);
    $display("Test hold done");
  endtask

  task automatic t_mode_off();
    setup(cfg(8'hff, 2'h0), cfg(8'hff, 2'h0), cfg(8'hff, 2'h0), cfg(8'hff, 2'h0), 32'h01010101);
    fifo_mode = 1'b0;
    repeat (200) tick(1'b0, 2'h0);
    fifo_mode = 1'b1;
    tick(1'b1, 2'h2);
    $display("Test mode_off done");
  endtask

  initial begin
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clock);
    t_rate_ends();
    t_burst();
    t_prio_rr();
    t_hold();
    t_mode_off();
    tally_and_finish();
  end
endmodule // tpra_arbiter_bench
